// file: core/usck_pkg.sv
// Purpose: constants and types for the serial clock generator and frame formatter
// Assumes: AXI4-Lite register access with 32-bit data, byte offsets below
// Notes: offsets are byte addresses
// Behaviour
// - Baud down-counter runs on clk, reloads at zero and on divisor low write.
// - One baud tick per counter zero, rate clk/(divisor+1).
// - Transmitter divides baud ticks by 2, 8 or 16 by mode.
// - Receiver uses baud ticks directly with 16 or 8 phase states async; sync samples on clock edges.
// - Bit rate is clk/16(d+1), clk/8(d+1) or clk/2(d+1).
// - Divisor is twelve bits from a four-bit high part and a low byte.
// - Double speed halves async divide and samples to 8; ignored in sync.
// - Slave transfer clock is synchronised then edge-detected before use.
// - Transfer clock pin is output as master, input as slave.
// - Input sampled on the clock edge opposite to output change.
// - Polarity zero: change on rise, sample on fall; one: reversed.
// - Accept 5 to 9 data bits, none/even/odd parity, 1 or 2 stops.
// - Start, data LSB first, parity, stops; next frame may follow directly.
// - Start bit low, stop bits high, idle line high.
// - Char size, parity mode and stop select fields set the format.
// - Receiver ignores second stop; frame error only if first stop low.
// - Receiver and transmitter share one format setting.
// - Even parity is XOR of data bits, odd is its inverse.
// - Parity inserted only when parity enable bit is one.
// - In sync mode clock direction picks master or slave clock.
package usck_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  localparam logic [7:0] OFF_DIV_LO = 8'h00;
  localparam logic [7:0] OFF_DIV_HI = 8'h04;
  localparam logic [7:0] OFF_CTRL_A = 8'h08;
  localparam logic [7:0] OFF_CTRL_B = 8'h0c;
  localparam logic [7:0] OFF_CTRL_C = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;

  localparam int CA_DBL = 1;
  localparam int CA_PE = 2;
  localparam int CA_FE = 4;
  localparam int CA_EMPTY = 5;
  localparam int CA_TXC = 6;
  localparam int CA_RXC = 7;

  localparam int CB_TXEN = 0;
  localparam int CB_RXEN = 1;
  localparam int CB_XDIR = 2;
  localparam int CB_TX9 = 3;

  localparam logic [11:0] DIV_RST = 12'h000;
  localparam logic [7:0] FMT_RST = 8'h03;
  localparam logic [3:0] CTRLB_RST = 4'h0;

  localparam logic [3:0] PRE_NORM = 4'hf;
  localparam logic [3:0] PRE_DBL = 4'h7;
  localparam logic [2:0] CSZ_NINE = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cpol;
    logic sync;
    logic [1:0] parity;
    logic stop2;
    logic [2:0] csz;
  } usck_fmt_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } usck_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } usck_rx_e;

endpackage : usck_pkg

// file: core/usck_clock_frame.sv
// Purpose: baud generator, transfer clock handling and serial frame engine
// Assumes: remote keeps its transfer clock under a quarter of clk
// Notes: all pins pass two flip-flops before any logic reads them
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module usck_clock_frame
  import usck_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial data pins
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutEn,
  // Transfer clock pin
  input wire logic xferClkIn,
  output logic xferClkOut,
  output logic xferClkOe
);

  function automatic logic [3:0] charBits(input logic [2:0] csz);
    logic [3:0] n;
    n = 4'h8;
    case (csz)
      3'h0: n = 4'h5;
      3'h1: n = 4'h6;
      3'h2: n = 4'h7;
      3'h3: n = 4'h8;
      CSZ_NINE: n = 4'h9;
      default: n = 4'h8;
    endcase
    return n;
  endfunction : charBits

  function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n,
                                    input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction : parityOf

  // Bus state
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  // Software registers
  logic [7:0] divLo_r;
  logic [3:0] divHi_r;
  logic dblSpeed_r;
  logic [3:0] ctrlB_r;
  usck_fmt_s fmt_r;
  logic [8:0] txBuf_r;
  logic txBufFull_r;
  logic txDone_r;
  logic [8:0] rxData_r;
  logic rxDone_r;
  logic frameErr_r;
  logic parErr_r;

  // Clocking
  logic [11:0] baudCnt_r;
  logic [3:0] txPre_r;
  logic [3:0] rxPhase_r;
  logic xckOut_r;
  logic xckS1_r;
  logic xckS2_r;
  logic xckS3_r;
  logic rxS1_r;
  logic rxS2_r;

  // Frame engines
  usck_tx_e txState_r;
  logic [3:0] txIdx_r;
  logic [8:0] txSh_r;
  logic txLine_r;
  usck_rx_e rxState_r;
  logic [3:0] rxIdx_r;
  logic [8:0] rxSh_r;

  logic wrEn;
  logic wrOk;
  logic wrDivLo;
  logic wrDivHi;
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrCtrlC;
  logic wrData;
  logic rdTake;
  logic rdDataHit;
  logic [31:0] rdVal;
  logic rdOk;
  logic [11:0] divisor;
  logic baudTick;
  logic [3:0] preTop;
  logic syncMode;
  logic master;
  logic txEn;
  logic rxEn;
  logic riseEv;
  logic fallEv;
  logic changeEv;
  logic sampleEv;
  logic txBitTick;
  logic rxSampleTick;
  logic [3:0] nBits;
  logic parEn;
  logic lastStop;
  logic txLoad;
  logic txDoneSet;
  logic rxFrameDone;

  // AXI4-Lite slave: address and data taken in either order
  assign s_axi_awready = ~awHeld_r & ~bValid_r;
  assign s_axi_wready = ~wHeld_r & ~bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  assign wrEn = awHeld_r & wHeld_r & ~bValid_r;
  assign wrOk = wrEn & wStrb_r[0];
  assign wrDivLo = wrOk & (awAddr_r == OFF_DIV_LO);
  assign wrDivHi = wrOk & (awAddr_r == OFF_DIV_HI);
  assign wrCtrlA = wrOk & (awAddr_r == OFF_CTRL_A);
  assign wrCtrlB = wrOk & (awAddr_r == OFF_CTRL_B);
  assign wrCtrlC = wrOk & (awAddr_r == OFF_CTRL_C);
  assign wrData = wrOk & (awAddr_r == OFF_DATA);
  assign rdTake = s_axi_arvalid & ~rValid_r;
  assign rdDataHit = rdTake & (s_axi_araddr == OFF_DATA);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (wrEn) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (wrEn) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else if (wrEn) begin
      bValid_r <= 1'b1;
      bResp_r <= (awAddr_r > OFF_DATA || awAddr_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    case (s_axi_araddr)
      OFF_DIV_LO: rdVal[7:0] = divLo_r;
      OFF_DIV_HI: rdVal[3:0] = divHi_r;
      OFF_CTRL_A: begin
        rdVal[CA_DBL] = dblSpeed_r;
        rdVal[CA_PE] = parErr_r;
        rdVal[CA_FE] = frameErr_r;
        rdVal[CA_EMPTY] = ~txBufFull_r;
        rdVal[CA_TXC] = txDone_r;
        rdVal[CA_RXC] = rxDone_r;
      end
      OFF_CTRL_B: rdVal[3:0] = ctrlB_r;
      OFF_CTRL_C: rdVal[7:0] = fmt_r;
      OFF_DATA: rdVal[8:0] = rxData_r;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
    end else if (rdTake) begin
      rValid_r <= 1'b1;
      rData_r <= rdVal;
      rResp_r <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Configuration registers; one format set serves both directions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divLo_r <= DIV_RST[7:0];
      divHi_r <= DIV_RST[11:8];
      dblSpeed_r <= 1'b0;
      ctrlB_r <= CTRLB_RST;
      fmt_r <= FMT_RST;
    end else begin
      if (wrDivLo) divLo_r <= wData_r[7:0];
      if (wrDivHi) divHi_r <= wData_r[3:0];
      if (wrCtrlA) dblSpeed_r <= wData_r[CA_DBL];
      if (wrCtrlB) ctrlB_r <= wData_r[3:0];
      if (wrCtrlC) fmt_r <= wData_r[7:0];
    end
  end

  assign divisor = {divHi_r, divLo_r};
  assign syncMode = fmt_r.sync;
  assign master = syncMode & ctrlB_r[CB_XDIR];
  assign txEn = ctrlB_r[CB_TXEN];
  assign rxEn = ctrlB_r[CB_RXEN];
  assign nBits = charBits(fmt_r.csz);
  assign parEn = fmt_r.parity[1];

  // Baud generator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      baudCnt_r <= DIV_RST;
    end else if (wrDivLo) begin
      baudCnt_r <= {divHi_r, wData_r[7:0]};
    end else if (baudCnt_r == 12'h000) begin
      baudCnt_r <= divisor;
    end else begin
      baudCnt_r <= baudCnt_r - 12'h001;
    end
  end

  assign baudTick = (baudCnt_r == 12'h000);
  assign preTop = (dblSpeed_r && !syncMode) ? PRE_DBL : PRE_NORM;

  // Master clock toggles per baud tick, giving the divide by two
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xckOut_r <= 1'b0;
    end else if (!master) begin
      xckOut_r <= 1'b0;
    end else if (baudTick) begin
      xckOut_r <= ~xckOut_r;
    end
  end

  // Slave clock and serial input synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xckS1_r <= 1'b0;
      xckS2_r <= 1'b0;
      xckS3_r <= 1'b0;
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
    end else begin
      xckS1_r <= xferClkIn;
      xckS2_r <= xckS1_r;
      xckS3_r <= xckS2_r;
      rxS1_r <= serialInPin;
      rxS2_r <= rxS1_r;
    end
  end

  always_comb begin
    if (master) begin
      riseEv = baudTick & ~xckOut_r;
      fallEv = baudTick & xckOut_r;
    end else begin
      riseEv = syncMode & xckS2_r & ~xckS3_r;
      fallEv = syncMode & ~xckS2_r & xckS3_r;
    end
  end

  assign changeEv = fmt_r.cpol ? fallEv : riseEv;
  assign sampleEv = fmt_r.cpol ? riseEv : fallEv;
  // Gated so the pin is low in the very cycle master mode is left
  assign xferClkOut = xckOut_r & master;
  assign xferClkOe = master;

  // Transmit prescaler, 16 or 8 baud ticks per bit in async modes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txPre_r <= 4'h0;
    end else if (baudTick) begin
      txPre_r <= (txPre_r >= preTop) ? 4'h0 : txPre_r + 4'h1;
    end
  end

  assign txBitTick = syncMode ? changeEv : (baudTick & (txPre_r >= preTop));
  assign lastStop = (txState_r == TX_STOP2) || (txState_r == TX_STOP1 && !fmt_r.stop2);
  assign txLoad = txEn & txBitTick & txBufFull_r & (lastStop || txState_r == TX_IDLE);
  assign txDoneSet = txEn & txBitTick & ~txBufFull_r & lastStop;

  // Transmit frame engine
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState_r <= TX_IDLE;
      txIdx_r <= 4'h0;
      txSh_r <= 9'h000;
      txLine_r <= 1'b1;
    end else if (!txEn) begin
      txState_r <= TX_IDLE;
      txLine_r <= 1'b1;
    end else if (txLoad) begin
      txSh_r <= txBuf_r;
      txLine_r <= 1'b0;
      txState_r <= TX_START;
    end else if (txBitTick) begin
      case (txState_r)
        TX_IDLE: txLine_r <= 1'b1;
        TX_START: begin
          txLine_r <= txSh_r[0];
          txIdx_r <= 4'h1;
          txState_r <= TX_DATA;
        end
        TX_DATA: begin
          if (txIdx_r >= nBits) begin
            txLine_r <= parEn ? parityOf(txSh_r, nBits, fmt_r.parity[0]) : 1'b1;
            txState_r <= parEn ? TX_PAR : TX_STOP1;
          end else begin
            txLine_r <= txSh_r[txIdx_r];
            txIdx_r <= txIdx_r + 4'h1;
          end
        end
        TX_PAR: begin
          txLine_r <= 1'b1;
          txState_r <= TX_STOP1;
        end
        TX_STOP1: begin
          txLine_r <= 1'b1;
          txState_r <= fmt_r.stop2 ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          txLine_r <= 1'b1;
          txState_r <= TX_IDLE;
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  assign serialOutPin = txLine_r;
  assign serialOutEn = txEn;

  // Transmit buffer and completion flag; setting beats clearing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txBuf_r <= 9'h000;
      txBufFull_r <= 1'b0;
    end else begin
      if (txLoad) txBufFull_r <= 1'b0;
      if (wrData) begin
        txBuf_r <= {ctrlB_r[CB_TX9], wData_r[7:0]};
        txBufFull_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txDone_r <= 1'b0;
    end else if (txDoneSet) begin
      txDone_r <= 1'b1;
    end else if (wrCtrlA && wData_r[CA_TXC]) begin
      txDone_r <= 1'b0;
    end
  end

  // Receive phase counter: 16 or 8 states per bit async, one edge per bit sync
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxPhase_r <= 4'h0;
    end else if (rxState_r == RX_IDLE) begin
      rxPhase_r <= 4'h0;
    end else if (baudTick) begin
      rxPhase_r <= (rxPhase_r >= preTop) ? 4'h0 : rxPhase_r + 4'h1;
    end
  end

  assign rxSampleTick = syncMode ? sampleEv
                                 : (baudTick & (rxPhase_r == (preTop >> 1)));
  assign rxFrameDone = rxEn & rxSampleTick & (rxState_r == RX_STOP);

  // Receive frame engine
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState_r <= RX_IDLE;
      rxIdx_r <= 4'h0;
      rxSh_r <= 9'h000;
    end else if (!rxEn) begin
      rxState_r <= RX_IDLE;
    end else begin
      case (rxState_r)
        RX_IDLE: begin
          rxIdx_r <= 4'h0;
          rxSh_r <= 9'h000;
          if (syncMode && sampleEv && !rxS2_r) begin
            rxState_r <= RX_DATA;
          end else if (!syncMode && baudTick && !rxS2_r) begin
            rxState_r <= RX_START;
          end
        end
        RX_START: begin
          if (rxSampleTick) begin
            rxState_r <= rxS2_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSampleTick) begin
            rxSh_r[rxIdx_r] <= rxS2_r;
            rxIdx_r <= rxIdx_r + 4'h1;
            if (rxIdx_r + 4'h1 >= nBits) begin
              rxState_r <= parEn ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rxSampleTick) rxState_r <= RX_STOP;
        end
        RX_STOP: begin
          if (rxSampleTick) rxState_r <= RX_IDLE;
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // Receive results; a new frame wins over a read in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxData_r <= 9'h000;
      rxDone_r <= 1'b0;
      frameErr_r <= 1'b0;
    end else if (rxFrameDone) begin
      rxData_r <= rxSh_r;
      rxDone_r <= 1'b1;
      frameErr_r <= ~rxS2_r;
    end else if (rdDataHit) begin
      rxDone_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      parErr_r <= 1'b0;
    end else if (rxEn && rxSampleTick && rxState_r == RX_PAR) begin
      parErr_r <= rxS2_r ^ parityOf(rxSh_r, nBits, fmt_r.parity[0]);
    end else if (rxEn && rxSampleTick && rxState_r == RX_START) begin
      parErr_r <= 1'b0;
    end
  end

endmodule : usck_clock_frame

// file: bench/usck_clock_frame_checker.sv
// Purpose: port-level assertions for the clock and frame block
// Assumes: one clock domain, reset active high
// Notes: sees only the top module ports
`timescale 1ns/1ps
module usck_clock_frame_checker
  import usck_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic serialOutPin,
  input wire logic serialOutEn,
  input wire logic xferClkOut,
  input wire logic xferClkOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ckPrev_r;
  logic ckMoved_r;
  // Remembers a transfer clock change one edge back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ckPrev_r <= 1'b0;
      ckMoved_r <= 1'b0;
    end else begin
      ckPrev_r <= xferClkOut;
      ckMoved_r <= xferClkOut != ckPrev_r;
    end
  end
  a_idle_line_high: assert property (!serialOutEn |-> serialOutPin)
    else $error("tx line low while disabled");
  a_start_bit_held: assert property (serialOutEn && $fell(serialOutPin) |=> !serialOutPin)
    else $error("start bit shorter than two clocks");
  a_clk_out_rest: assert property (!xferClkOe |-> !xferClkOut)
    else $error("clock output moves while not master");
  a_data_on_edge: assert property (xferClkOe && serialOutEn && $changed(serialOutPin)
    |-> $changed(xferClkOut) || ckMoved_r)
    else $error("tx data changed away from a clock edge");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : usck_clock_frame_checker

bind usck_clock_frame usck_clock_frame_checker chk (
  .clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
  .xferClkOut(xferClkOut), .xferClkOe(xferClkOe)
);

// file: bench/usck_remote.sv
// Purpose: remote serial transceiver on the data and clock lines
// Assumes: released tx line reads high through a pull-up
// Notes: slave clock runs only while a frame is expected
`timescale 1ns/1ps
module usck_remote
  import usck_pkg::*;
(
  // Clock
  input wire logic clk,
  // Lines from the block
  input wire logic txLine,
  input wire logic clkOut,
  input wire logic clkOe,
  // Lines to the block
  output logic rxLine,
  output logic clkIn
);
  logic seenClk;
  assign seenClk = clkOe ? clkOut : clkIn;
  initial begin
    rxLine = 1'b1;
    clkIn = 1'b0;
  end
  task automatic sendFrame(input logic [11:0] f, input int n, input int bitClk);
    int i;
    for (i = 0; i < n; i++) begin
      rxLine <= f[i];
      repeat (bitClk) @(posedge clk);
    end
    rxLine <= 1'b1;
  endtask : sendFrame
  // Below a quarter of clk, stops low after an even count
  task automatic slaveClock(input int edges, input int half);
    int i;
    for (i = 0; i < edges; i++) begin
      repeat (half) @(posedge clk);
      clkIn <= ~clkIn;
    end
  endtask : slaveClock
  task automatic capture(input int n, input int bitClk, input bit sync, input bit pol,
                         output logic [11:0] b, output bit ok);
    int i;
    int k;
    logic pc;
    b = '1;
    i = 0;
    k = 0;
    pc = seenClk;
    while (k < 3000 && i < n) begin
      @(posedge clk);
      k++;
      if (sync) begin
        // Sample on the edge opposite to the change edge
        if (pc != seenClk && seenClk == pol && (i > 0 || !txLine)) begin
          b[i] = txLine;
          i++;
        end
        pc = seenClk;
      end else if (!txLine) begin
        repeat (bitClk / 2) @(posedge clk);
        for (i = 0; i < n; i++) begin
          b[i] = txLine;
          repeat (bitClk) @(posedge clk);
        end
      end
    end
    ok = (i == n);
  endtask : capture
endmodule : usck_remote

// file: bench/test_usart_clock_and_frame_format.sv
// Purpose: self-checking bench for the clock and frame block
// Assumes: bus tasks speak AXI4-Lite, remote model on the lines
// Notes: frame expectations are built from the format fields
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checkCount++; if ((got) !== (exp)) begin errCount++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_usart_clock_and_frame_format
  import usck_pkg::*;
;
  logic clk = 1'b0;
  logic sysRst;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic serialOut, serialOutEn, clkOut, clkOe, serialIn, clkIn, txLine;
  logic [11:0] f;
  int errCount = 0;
  int checkCount = 0;
  int i;
  always #25 clk = ~clk;
  assign txLine = serialOutEn ? serialOut : 1'b1;
  usck_clock_frame dut (.clk(clk), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .serialInPin(serialIn), .serialOutPin(serialOut), .serialOutEn(serialOutEn),
    .xferClkIn(clkIn), .xferClkOut(clkOut), .xferClkOe(clkOe));
  usck_remote remote (.clk(clk), .txLine(txLine), .clkOut(clkOut), .clkOe(clkOe),
    .rxLine(serialIn), .clkIn(clkIn));
  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : giveVerdict
  task automatic waitFailed();
    errCount++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    giveVerdict();
  endtask : waitFailed
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    for (n = 0; n < 40 && !bValid; n++) begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end
    if (!bValid) waitFailed();
    bReady <= 1'b1;
    @(posedge clk);
    `CHECK_EQ(bResp, er)
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    for (n = 0; n < 40 && !rValid; n++) begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
    end
    if (!rValid) waitFailed();
    rReady <= 1'b1;
    @(posedge clk);
    `CHECK_EQ(rData & m, e)
    `CHECK_EQ(rResp, er)
    rReady <= 1'b0;
  endtask : rd
  function automatic logic [11:0] frame(input logic [8:0] d, input int nd,
                                        input logic [1:0] par);
    logic [11:0] g;
    logic p;
    int k;
    g = '1;
    g[0] = 1'b0;
    p = par[0];
    for (k = 0; k < nd; k++) begin
      g[k + 1] = d[k];
      p = p ^ d[k];
    end
    if (par[1]) g[nd + 1] = p;
    return g;
  endfunction : frame
  task automatic txCase(input logic [7:0] fmt, input logic dir, input logic [8:0] d,
                        input int bitClk, input logic [31:0] ctrlA);
    logic [11:0] b;
    bit ok;
    int nd;
    int n;
    nd = (fmt[2:0] == CSZ_NINE) ? 9 : (fmt[2:0] > 3'h3) ? 8 : fmt[2:0] + 5;
    n = 2 + nd + fmt[5] + fmt[3];
    wr(OFF_CTRL_C, {24'h0, fmt}, RESP_OKAY);
    wr(OFF_CTRL_B, {28'h0, d[8], dir, 2'b11}, RESP_OKAY);
    fork
      remote.capture(n, bitClk, fmt[6], fmt[7], b, ok);
      wr(OFF_DATA, {23'h0, d}, RESP_OKAY);
      if (fmt[6] && !dir) remote.slaveClock(28, 6);
    join
    `CHECK_EQ(ok, 1'b1)
    `CHECK_EQ(b, frame(d, nd, fmt[5:4]))
    repeat (bitClk) @(posedge clk);
    rd(OFF_CTRL_A, 32'h40, 32'h40, RESP_OKAY);
    wr(OFF_CTRL_A, ctrlA | 32'h40, RESP_OKAY);
  endtask : txCase
  initial begin
    repeat (100000) @(posedge clk);
    waitFailed();
  end
  initial begin
    sysRst = 1'b1;
    {awAddr, arAddr, wData} = '0;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    rd(OFF_DIV_LO, 32'hffff_ffff, 32'h0, RESP_OKAY);
    rd(OFF_CTRL_A, 32'hffff_ffff, 32'h20, RESP_OKAY);
    rd(OFF_CTRL_C, 32'hffff_ffff, {24'h0, FMT_RST}, RESP_OKAY);
    `CHECK_EQ(serialOut, 1'b1)
    `CHECK_EQ(clkOe, 1'b0)
    rd(8'h40, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    rd(8'h02, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFF_DIV_HI, 32'hfff, RESP_OKAY);
    rd(OFF_DIV_HI, 32'hffff_ffff, 32'hf, RESP_OKAY);
    wr(OFF_DIV_HI, 32'h0, RESP_OKAY);
    wr(OFF_DIV_LO, 32'h0, RESP_OKAY);
    $display("test registers: done");
    txCase(8'h03, 1'b0, 9'h0a5, 16, 0);
    txCase(8'h28, 1'b0, 9'h013, 16, 0);
    txCase(8'h32, 1'b0, 9'h05b, 16, 0);
    txCase(8'h39, 1'b0, 9'h02c, 16, 0);
    txCase(8'h27, 1'b0, 9'h1c6, 16, 0);
    txCase(8'h13, 1'b0, 9'h0f0, 16, 0);
    $display("test async formats: done");
    wr(OFF_CTRL_A, 32'h2, RESP_OKAY);
    txCase(8'h03, 1'b0, 9'h05a, 8, 32'h2);
    wr(OFF_CTRL_A, 32'h0, RESP_OKAY);
    wr(OFF_DIV_LO, 32'h2, RESP_OKAY);
    txCase(8'h03, 1'b0, 9'h0c9, 48, 0);
    wr(OFF_DIV_LO, 32'h0, RESP_OKAY);
    $display("test rate: done");
    for (i = 0; i < 4; i++) begin
      wr(OFF_CTRL_C, (i == 2) ? 32'h2b : 32'h23, RESP_OKAY);
      f = frame(9'h0c5 + i[8:0], 8, 2'b10);
      if (i == 1) f[10] = 1'b0;
      if (i == 2) f[11] = 1'b0;
      if (i == 3) f[9] = ~f[9];
      remote.sendFrame(f, 12, 16);
      rd(OFF_CTRL_A, 32'h94, (i == 1) ? 32'h90 : (i == 3) ? 32'h84 : 32'h80, RESP_OKAY);
      rd(OFF_DATA, 32'h1ff, 32'h0c5 + i, RESP_OKAY);
      // A low second stop reads as a new start bit; let that frame finish
      if (i == 2) repeat (200) @(posedge clk);
    end
    $display("test receive: done");
    wr(OFF_DIV_LO, 32'h3, RESP_OKAY);
    txCase(8'h43, 1'b1, 9'h0b4, 8, 0);
    `CHECK_EQ(clkOe, 1'b1)
    txCase(8'hc3, 1'b1, 9'h0c3, 8, 0);
    txCase(8'h43, 1'b0, 9'h16d, 12, 0);
    `CHECK_EQ(clkOe, 1'b0)
    $display("test sync: done");
    giveVerdict();
  end
endmodule : test_usart_clock_and_frame_format
